// file: clock_select_pkg.sv
// Constants and types shared by the CPU and peripheral clock selector
package clock_select_pkg;

    localparam int unsigned SYS_CLK_HZ       = 200_000_000;
    localparam int unsigned LOW_SPEED_HZ     = 240_000;
    localparam int unsigned LOW_SPEED_DIV    = SYS_CLK_HZ / LOW_SPEED_HZ;

    localparam int unsigned DIV_CODE_WIDTH   = 3;
    localparam logic [2:0]  DIV_CODE_MAX     = 3'h4;
    localparam logic [2:0]  DIV_CODE_RESET   = 3'h1;
    localparam int unsigned DIV_COUNT_WIDTH  = 5;

    localparam int unsigned SYNC_STAGES      = 2;
    localparam int unsigned PIN_COUNT        = 3;
    localparam int unsigned PIN_SUB_RES      = 0;
    localparam int unsigned PIN_SUB_EXT      = 1;
    localparam int unsigned PIN_MAIN_EXT     = 2;

    localparam int unsigned MAIN_MODE_CPU_HS_BIT  = 0;
    localparam int unsigned MAIN_MODE_SOURCE_BIT  = 2;
    localparam int unsigned MODE_SEL_GAIN_BIT     = 0;
    localparam int unsigned MODE_SEL_SUB_EN_BIT   = 4;
    localparam int unsigned MODE_SEL_SUB_EXT_BIT  = 5;
    localparam int unsigned MODE_SEL_MAIN_EN_BIT  = 6;
    localparam int unsigned MODE_SEL_MAIN_EXT_BIT = 7;
    localparam int unsigned PROC_DIV_LSB          = 0;
    localparam int unsigned PROC_SOURCE_BIT       = 4;
    localparam int unsigned PROC_SUB_STATUS_BIT   = 5;
    localparam int unsigned PROC_SUB_START_BIT    = 6;
    localparam int unsigned MAIN_MODE_STATUS_BIT  = 1;

    typedef enum logic [1:0] {
        SUB_PIN_PORT,
        SUB_PIN_RESONATOR,
        SUB_PIN_EXTERNAL
    } sub_pin_mode_type;

    typedef enum logic [1:0] {
        CPU_FROM_INTERNAL_HS,
        CPU_FROM_HIGHSPEED,
        CPU_FROM_SUB
    } cpu_source_type;

endpackage

// file: low_speed_oscillator.sv
// Internal low-speed oscillator modelled as a tick divider off sys_clk
`timescale 1ns/1ps
module low_speed_oscillator
    import clock_select_pkg::*;
#(
    parameter int unsigned DIVIDE = LOW_SPEED_DIV
)(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      tick
);
    localparam int unsigned CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count;

    always_ff @(posedge sys_clk)
    begin
        if (reset || !run)
            count <= '0;
        else if (count == LAST)
            count <= '0;
        else
            count <= count + CW'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tick <= 1'b0;
        else
            tick <= run && (count == LAST);
    end
endmodule // low_speed_oscillator

// file: cpu_peripheral_clock_selector.sv
// CPU and peripheral clock source selection, subsystem pins and low-speed oscillator
// How it works
// - Start 0, external select 1, enable 1: subsystem pins take external clock input.
// - CPU on subsystem gets subsystem clock halved for divider codes 000 to 100.
// - Two status flags report CPU source: sub, internal high-speed or high-speed.
// - Clearing subsystem enable with start 0 stops resonator and ignores external subsystem input.
// - STOP standby leaves the subsystem oscillator running until its enable clears.
// - Low-speed clock never reaches CPU; only watchdog and 8-bit timer.
// - Low-speed oscillator starts after reset at 240 kHz, clocking enabled watchdog.
// - Low-speed stop bit at 1 stops the low-speed oscillator.
// - Low-speed stop bit at 0 restarts the low-speed oscillator.
// - Option byte non-stoppable mode ignores the low-speed stop bit.
// - Main source select 0 gives internal high-speed to main and peripherals.
// - External main select picks resonator at 0, external input at 1.
// - CPU source select 1 runs CPU on subsystem; peripherals keep main choice.
// - After reset the CPU runs from internal high-speed with no writes.
// - Resonator start bit 1 forces subsystem resonator mode regardless of other bits.
`timescale 1ns/1ps
module cpu_peripheral_clock_selector
    import clock_select_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      sub_resonator_start,
    input  wire logic                      sub_external_input_select,
    input  wire logic                      sub_oscillator_enable,
    input  wire logic                      cpu_source_is_sub,
    input  wire logic [DIV_CODE_WIDTH-1:0] cpu_divider_code,
    input  wire logic                      main_source_select,
    input  wire logic                      main_cpu_highspeed_select,
    input  wire logic                      main_external_input_select,
    input  wire logic                      main_oscillator_enable,
    input  wire logic                      high_freq_gain,
    input  wire logic                      main_oscillator_stop,
    input  wire logic                      low_speed_osc_stop,
    input  wire logic                      low_speed_stoppable,
    input  wire logic                      watchdog_enable,
    input  wire logic                      timer8_uses_low_speed,
    input  wire logic                      stop_mode,
    input  wire logic                      internal_hs_tick,
    input  wire logic                      main_resonator_tick,
    input  wire logic                      main_external_pin,
    input  wire logic                      sub_resonator_pin,
    input  wire logic                      sub_external_pin,
    output sub_pin_mode_type               sub_pin_mode,
    output logic                           sub_resonator_drive,
    output logic                           main_resonator_drive,
    output logic                           main_resonator_gain,
    output logic                           cpu_on_sub_status,
    output logic                           main_on_highspeed_status,
    output logic [DIV_CODE_WIDTH-1:0]      cpu_divider_active,
    output logic                           cpu_clock_tick,
    output logic                           peripheral_clock_tick,
    output logic                           low_speed_running,
    output logic                           watchdog_clock_tick,
    output logic                           timer8_clock_tick,
    output logic [7:0]                     processor_clock_control,
    output logic [7:0]                     main_clock_mode,
    output logic [7:0]                     clock_mode_select
);

    logic [PIN_COUNT-1:0]   pin_raw;
    logic [PIN_COUNT-1:0]   pin_edge;
    logic [PIN_COUNT-1:0]   pin_prev;
    sub_pin_mode_type       next_sub_pin_mode;
    cpu_source_type         cpu_source;
    logic                   sub_edge;
    logic                   sub_half;
    logic                   hs_available;
    logic                   hs_tick;
    logic                   main_sys_tick;
    logic                   periph_tick;
    logic [DIV_COUNT_WIDTH-1:0] div_count;
    logic [DIV_COUNT_WIDTH-1:0] div_last;
    logic                   ls_tick;

    assign pin_raw = {main_external_pin, sub_external_pin, sub_resonator_pin};

    // Two-stage synchroniser per pin; edge detect reads only the second stage
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++)
        begin : g_pin_sync
            logic [SYNC_STAGES-1:0] stage;
            always_ff @(posedge sys_clk)
            begin
                if (reset)
                begin
                    stage       <= '0;
                    pin_prev[g] <= 1'b0;
                end
                else
                begin
                    stage       <= {stage[SYNC_STAGES-2:0], pin_raw[g]};
                    pin_prev[g] <= stage[SYNC_STAGES-1];
                end
            end
            assign pin_edge[g] = stage[SYNC_STAGES-1] && !pin_prev[g];
        end
    endgenerate

    always_comb
    begin
        if (sub_resonator_start)
            next_sub_pin_mode = SUB_PIN_RESONATOR;
        else if (!sub_oscillator_enable)
            next_sub_pin_mode = SUB_PIN_PORT;
        else if (sub_external_input_select)
            next_sub_pin_mode = SUB_PIN_EXTERNAL;
        else
            next_sub_pin_mode = SUB_PIN_RESONATOR;
    end

    // Stop mode is deliberately absent: the subsystem keeps running in STOP
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sub_pin_mode        <= SUB_PIN_PORT;
            sub_resonator_drive <= 1'b0;
        end
        else
        begin
            sub_pin_mode        <= next_sub_pin_mode;
            sub_resonator_drive <= (next_sub_pin_mode == SUB_PIN_RESONATOR);
        end
    end

    always_comb
    begin
        case (sub_pin_mode)
            SUB_PIN_RESONATOR: sub_edge = pin_edge[PIN_SUB_RES];
            SUB_PIN_EXTERNAL:  sub_edge = pin_edge[PIN_SUB_EXT];
            default:           sub_edge = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sub_half <= 1'b0;
        else if (sub_edge)
            sub_half <= !sub_half;
    end

    // High-speed system clock: resonator or external input
    assign hs_available = main_oscillator_enable && !main_oscillator_stop;
    assign hs_tick = hs_available && (main_external_input_select ?
                     pin_edge[PIN_MAIN_EXT] : main_resonator_tick);

    always_comb
    begin
        if (!main_source_select)
        begin
            main_sys_tick = internal_hs_tick;
            periph_tick   = internal_hs_tick;
        end
        else
        begin
            main_sys_tick = main_cpu_highspeed_select ? hs_tick : internal_hs_tick;
            periph_tick   = hs_tick;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            main_resonator_drive <= 1'b0;
        else
            main_resonator_drive <= hs_available && !main_external_input_select;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            main_resonator_gain <= 1'b0;
        else
            main_resonator_gain <= high_freq_gain;
    end

    // A prohibited code is dropped so the CPU clock is never undefined
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cpu_divider_active <= DIV_CODE_RESET;
        else if (cpu_divider_code <= DIV_CODE_MAX)
            cpu_divider_active <= cpu_divider_code;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cpu_source <= CPU_FROM_INTERNAL_HS;
        else if (cpu_source_is_sub)
            cpu_source <= CPU_FROM_SUB;
        else if (main_source_select && main_cpu_highspeed_select)
            cpu_source <= CPU_FROM_HIGHSPEED;
        else
            cpu_source <= CPU_FROM_INTERNAL_HS;
    end

    assign cpu_on_sub_status        = (cpu_source == CPU_FROM_SUB);
    assign main_on_highspeed_status = (cpu_source == CPU_FROM_HIGHSPEED);

    assign div_last = DIV_COUNT_WIDTH'((1 << cpu_divider_active) - 1);

    always_ff @(posedge sys_clk)
    begin
        if (reset || cpu_source == CPU_FROM_SUB)
            div_count <= '0;
        else if (main_sys_tick)
            div_count <= (div_count >= div_last) ? '0 : div_count + DIV_COUNT_WIDTH'(1);
    end

    // Low-speed clock is never a CPU source
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cpu_clock_tick <= 1'b0;
        else if (stop_mode)
            cpu_clock_tick <= 1'b0;
        else if (cpu_source == CPU_FROM_SUB)
            cpu_clock_tick <= sub_edge && sub_half;
        else
            cpu_clock_tick <= main_sys_tick && (div_count >= div_last);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            peripheral_clock_tick <= 1'b0;
        else
            peripheral_clock_tick <= periph_tick && !stop_mode;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            low_speed_running <= 1'b1;
        else if (!low_speed_stoppable)
            low_speed_running <= 1'b1;
        else
            low_speed_running <= !low_speed_osc_stop;
    end

    low_speed_oscillator #(
        .DIVIDE (LOW_SPEED_DIV)
    ) u_low_speed (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (low_speed_running),
        .tick    (ls_tick)
    );

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            watchdog_clock_tick <= 1'b0;
            timer8_clock_tick   <= 1'b0;
        end
        else
        begin
            watchdog_clock_tick <= ls_tick && watchdog_enable;
            timer8_clock_tick   <= ls_tick && timer8_uses_low_speed;
        end
    end

    always_comb
    begin
        processor_clock_control = 8'h00;
        processor_clock_control[PROC_DIV_LSB +: DIV_CODE_WIDTH] = cpu_divider_active;
        processor_clock_control[PROC_SOURCE_BIT]     = cpu_source_is_sub;
        processor_clock_control[PROC_SUB_STATUS_BIT] = cpu_on_sub_status;
        processor_clock_control[PROC_SUB_START_BIT]  = sub_resonator_start;
        main_clock_mode = 8'h00;
        main_clock_mode[MAIN_MODE_CPU_HS_BIT] = main_cpu_highspeed_select;
        main_clock_mode[MAIN_MODE_STATUS_BIT] = main_on_highspeed_status;
        main_clock_mode[MAIN_MODE_SOURCE_BIT] = main_source_select;
        clock_mode_select = 8'h00;
        clock_mode_select[MODE_SEL_GAIN_BIT]     = high_freq_gain;
        clock_mode_select[MODE_SEL_SUB_EN_BIT]   = sub_oscillator_enable;
        clock_mode_select[MODE_SEL_SUB_EXT_BIT]  = sub_external_input_select;
        clock_mode_select[MODE_SEL_MAIN_EN_BIT]  = main_oscillator_enable;
        clock_mode_select[MODE_SEL_MAIN_EXT_BIT] = main_external_input_select;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_EXT_MODE: assert property (
        (!sub_resonator_start && sub_external_input_select && sub_oscillator_enable)
        |=> sub_pin_mode == SUB_PIN_EXTERNAL && !sub_resonator_drive)
        else $error("External subsystem mode not entered");
    AST_SUB_HALF: assert property (
        (cpu_source == CPU_FROM_SUB && !stop_mode && sub_edge && !sub_half) |=> !cpu_clock_tick)
        else $error("CPU ticked on an odd subsystem edge");
    AST_STATUS: assert property (
        $rose(cpu_source_is_sub) |=> cpu_on_sub_status && !main_on_highspeed_status)
        else $error("Subsystem status flag did not follow source select");
    AST_SUB_OFF: assert property (
        (!sub_resonator_start && !sub_oscillator_enable) |=> !sub_edge && !sub_resonator_drive)
        else $error("Subsystem clock accepted while disabled");
    AST_STOP_KEEPS_SUB: assert property (
        (stop_mode && sub_oscillator_enable && !sub_external_input_select) |=>
        sub_pin_mode == SUB_PIN_RESONATOR)
        else $error("STOP halted the subsystem oscillator");
    AST_LS_STOP: assert property (
        (low_speed_stoppable && low_speed_osc_stop) [*2] |=> !ls_tick)
        else $error("Low-speed oscillator ticked while stopped");
    AST_LS_FORCED: assert property (
        !low_speed_stoppable |=> low_speed_running)
        else $error("Non-stoppable low-speed oscillator stopped");
    AST_INTERNAL_MAIN: assert property (
        (!main_source_select && !stop_mode) |=> peripheral_clock_tick == $past(internal_hs_tick))
        else $error("Peripheral clock not internal high-speed");
    AST_DIV_HOLD: assert property (
        (cpu_divider_code > DIV_CODE_MAX) |=> $stable(cpu_divider_active))
        else $error("Prohibited divider code took effect");
    AST_RESON_START: assert property (
        sub_resonator_start |=> sub_pin_mode == SUB_PIN_RESONATOR)
        else $error("Resonator start did not force resonator mode");

    COV_SUB_CPU:   cover property (cpu_on_sub_status && cpu_clock_tick);
    COV_HS_CPU:    cover property (main_on_highspeed_status && cpu_clock_tick);
    COV_WDT_TICK:  cover property (watchdog_clock_tick);
    COV_BAD_DIV:   cover property (cpu_divider_code > DIV_CODE_MAX);

endmodule // cpu_peripheral_clock_selector

// file: clock_source_model.sv
// Far-side clock sources: subsystem crystal, external clock pins and main crystal
`timescale 1ns/1ps
module clock_source_model #(
    parameter int unsigned SUB_HALF   = 7,
    parameter int unsigned EXT_HALF   = 5,
    parameter int unsigned RES_PERIOD = 16
)(
    input  wire logic sys_clk,
    input  wire logic sub_res_drive,
    input  wire logic sub_ext_run,
    input  wire logic main_res_drive,
    input  wire logic main_ext_run,
    output logic      sub_res_pin,
    output logic      sub_ext_pin,
    output logic      main_ext_pin,
    output logic      main_res_tick
);
    int unsigned sub_cnt = 0;
    int unsigned ext_cnt = 0;
    int unsigned res_cnt = 0;

    initial {sub_res_pin, sub_ext_pin, main_ext_pin, main_res_tick} = 4'h0;

    // A crystal only swings while the device drives it; a fresh start waits a full period (main) or a half period (subsystem)
    always @(posedge sys_clk)
    begin
        sub_cnt <= sub_res_drive ? (sub_cnt + 1) % SUB_HALF : 0;
        if (!sub_res_drive)
            sub_res_pin <= 1'b0;
        else if (sub_cnt == SUB_HALF - 1)
            sub_res_pin <= !sub_res_pin;
        ext_cnt <= (ext_cnt + 1) % EXT_HALF;
        if (ext_cnt == EXT_HALF - 1)
        begin
            sub_ext_pin  <= sub_ext_run ? !sub_ext_pin : 1'b0;
            main_ext_pin <= main_ext_run ? !main_ext_pin : 1'b0;
        end
        res_cnt       <= main_res_drive ? (res_cnt + 1) % RES_PERIOD : 0;
        main_res_tick <= main_res_drive && res_cnt == RES_PERIOD - 1;
    end
endmodule // clock_source_model

// file: cpu_peripheral_clock_selector_tb.sv
// Self-checking bench for the CPU and peripheral clock selector
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %s expected %0d seen %0d", nm, (exp), (got)); end end
module cpu_peripheral_clock_selector_tb import clock_select_pkg::*;;
    logic sys_clk = 1'b0;
    logic reset;
    logic sub_resonator_start, sub_external_input_select, sub_oscillator_enable;
    logic cpu_source_is_sub, main_source_select, main_cpu_highspeed_select;
    logic main_external_input_select, main_oscillator_enable, high_freq_gain;
    logic main_oscillator_stop, low_speed_osc_stop, low_speed_stoppable;
    logic watchdog_enable, timer8_uses_low_speed, stop_mode;
    logic internal_hs_tick = 1'b0;
    logic main_resonator_tick, main_external_pin, sub_resonator_pin, sub_external_pin;
    logic [DIV_CODE_WIDTH-1:0] cpu_divider_code, cpu_divider_active;
    sub_pin_mode_type sub_pin_mode;
    logic sub_resonator_drive, main_resonator_drive, main_resonator_gain;
    logic cpu_on_sub_status, main_on_highspeed_status, cpu_clock_tick, peripheral_clock_tick;
    logic low_speed_running, watchdog_clock_tick, timer8_clock_tick;
    logic [7:0] processor_clock_control, main_clock_mode, clock_mode_select;
    logic sub_ext_run = 1'b0;
    logic main_ext_run = 1'b0;
    logic prev_sub = 1'b0;
    logic prev_main = 1'b0;
    integer n_cpu = 0, n_per = 0, n_res = 0, n_wd = 0, n_t8 = 0, r_sub = 0, r_main = 0;
    integer b_cpu, b_per, b_res, b_wd, b_t8, b_sub, b_main;
    integer err_count = 0, comparisons = 0, cycles = 0;
    int hs_goal = 0;
    int hs_sent = 0;
    int hs_phase = 0;

    always #2.5 sys_clk = ~sys_clk;

    cpu_peripheral_clock_selector u_dut (.*);

    clock_source_model u_src (.sys_clk(sys_clk), .sub_res_drive(sub_resonator_drive),
        .sub_ext_run(sub_ext_run), .main_res_drive(main_resonator_drive),
        .main_ext_run(main_ext_run), .sub_res_pin(sub_resonator_pin),
        .sub_ext_pin(sub_external_pin), .main_ext_pin(main_external_pin),
        .main_res_tick(main_resonator_tick));

    // Counters are four-state so an unknown tick spoils the count
    // Outputs are unknown before the first reset edge, so reset cycles are not counted
    always @(posedge sys_clk)
    begin
        if (!reset)
        begin
            n_cpu += cpu_clock_tick;
            n_per += peripheral_clock_tick;
            n_res += main_resonator_tick;
            n_wd += watchdog_clock_tick;
            n_t8 += timer8_clock_tick;
        end
        r_sub += sub_external_pin && !prev_sub;
        r_main += main_external_pin && !prev_main;
        prev_sub = sub_external_pin;
        prev_main = main_external_pin;
        internal_hs_tick <= hs_sent < hs_goal && hs_phase == 0;
        if (hs_sent < hs_goal && hs_phase == 0)
            hs_sent <= hs_sent + 1;
        hs_phase <= (hs_phase + 1) % 3;
    end

    // Every wait goes through here, so the run-length limit lives here too
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            cycles++;
        end
        if (cycles > 20000)
        begin
            err_count++;
            $display("[FAIL] run length expected 20000 seen %0d", cycles);
            test_done;
        end
    endtask

    task automatic snap;
        {b_cpu, b_per, b_res, b_wd, b_t8, b_sub, b_main} = {n_cpu, n_per, n_res, n_wd, n_t8,
            r_sub, r_main};
    endtask

    task automatic do_reset;
        reset <= 1'b1;
        {sub_resonator_start, sub_external_input_select, sub_oscillator_enable} <= 3'h0;
        {cpu_source_is_sub, main_source_select, main_cpu_highspeed_select} <= 3'h0;
        {main_external_input_select, main_oscillator_enable, high_freq_gain} <= 3'h0;
        {main_oscillator_stop, low_speed_osc_stop, low_speed_stoppable} <= 3'h5;
        {watchdog_enable, timer8_uses_low_speed, stop_mode} <= 3'h0;
        cpu_divider_code <= DIV_CODE_RESET;
        step(3);
        reset <= 1'b0;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic test_reset;
        do_reset;
        step(2);
        snap;
        hs_goal <= hs_sent + 8;
        step(40);
        `CHECK("cpu status", 2'h0, {cpu_on_sub_status, main_on_highspeed_status})
        `CHECK("divider", DIV_CODE_RESET, cpu_divider_active)
        `CHECK("cpu ticks", 8 >> DIV_CODE_RESET, n_cpu - b_cpu)
        `CHECK("low speed running", 1'b1, low_speed_running)
    endtask

    task automatic test_sub_pins;
        logic [2:0] combo [6] = '{3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
        sub_pin_mode_type want [6] = '{SUB_PIN_EXTERNAL, SUB_PIN_RESONATOR, SUB_PIN_RESONATOR,
            SUB_PIN_RESONATOR, SUB_PIN_PORT, SUB_PIN_PORT};
        for (int i = 0; i < 6; i++)
        begin
            // Fresh reset per setting, so the bits never move under a running clock
            do_reset;
            {sub_resonator_start, sub_external_input_select, sub_oscillator_enable}
                <= combo[i];
            stop_mode <= 1'b1;
            step(3);
            `CHECK("pin mode", want[i], sub_pin_mode)
            `CHECK("sub drive", want[i] == SUB_PIN_RESONATOR, sub_resonator_drive)
        end
    endtask

    task automatic test_cpu_sub;
        do_reset;
        sub_external_input_select <= 1'b1;
        sub_oscillator_enable <= 1'b1;
        cpu_divider_code <= 3'h4;
        step(3);
        cpu_source_is_sub <= 1'b1;
        step(2);
        `CHECK("cpu on sub", 1'b1, cpu_on_sub_status)
        `CHECK("source image", 1'b1, processor_clock_control[PROC_SOURCE_BIT])
        snap;
        sub_ext_run <= 1'b1;
        hs_goal <= hs_sent + 20;
        step(220);
        sub_ext_run <= 1'b0;
        step(10);
        `CHECK("cpu ticks on sub", (r_sub - b_sub) / 2, n_cpu - b_cpu)
        `CHECK("peripheral ticks", 20, n_per - b_per)
        cpu_source_is_sub <= 1'b0;
        step(3);
        `CHECK("cpu off sub", 1'b0, cpu_on_sub_status)
        sub_oscillator_enable <= 1'b0;
        step(3);
        `CHECK("pin mode", SUB_PIN_PORT, sub_pin_mode)
    endtask

    task automatic test_divider;
        logic [2:0] last;
        do_reset;
        cpu_divider_code <= 3'h2;
        step(2);
        snap;
        hs_goal <= hs_sent + 32;
        step(110);
        `CHECK("cpu ticks", 32 >> 2, n_cpu - b_cpu)
        `CHECK("peripheral ticks", 32, n_per - b_per)
        last = 3'h2;
        for (int c = 7; c >= 0; c--)
        begin
            cpu_divider_code <= c[2:0];
            step(2);
            if (c <= DIV_CODE_MAX)
                last = c[2:0];
            `CHECK("divider code", last, cpu_divider_active)
        end
    endtask

    task automatic test_highspeed;
        do_reset;
        snap;
        high_freq_gain <= 1'b1;
        main_oscillator_enable <= 1'b1;
        step(1);
        main_oscillator_stop <= 1'b0;
        step(1);
        main_source_select <= 1'b1;
        main_cpu_highspeed_select <= 1'b1;
        cpu_divider_code <= 3'h0;
        step(3);
        `CHECK("crystal drive", 1'b1, main_resonator_drive)
        `CHECK("gain", 1'b1, main_resonator_gain)
        `CHECK("cpu status", 2'h1, {cpu_on_sub_status, main_on_highspeed_status})
        `CHECK("main image", 1'b1, main_clock_mode[MAIN_MODE_SOURCE_BIT])
        step(150);
        main_oscillator_stop <= 1'b1;
        step(5);
        `CHECK("cpu ticks", n_res - b_res, n_cpu - b_cpu)
        `CHECK("peripheral ticks", n_res - b_res, n_per - b_per)
        main_external_input_select <= 1'b1;
        main_oscillator_stop <= 1'b0;
        step(3);
        `CHECK("crystal drive", 1'b0, main_resonator_drive)
        `CHECK("ext image", 1'b1, clock_mode_select[MODE_SEL_MAIN_EXT_BIT])
        snap;
        main_ext_run <= 1'b1;
        step(100);
        main_ext_run <= 1'b0;
        step(10);
        `CHECK("cpu ticks ext", r_main - b_main, n_cpu - b_cpu)
    endtask

    task automatic test_low_speed;
        do_reset;
        watchdog_enable <= 1'b1;
        timer8_uses_low_speed <= 1'b1;
        step(3);
        `CHECK("low speed running", 1'b1, low_speed_running)
        snap;
        step(2 * LOW_SPEED_DIV);
        `CHECK("watchdog ticks", 2, n_wd - b_wd)
        `CHECK("timer8 ticks", 2, n_t8 - b_t8)
        `CHECK("cpu ticks", 0, n_cpu - b_cpu)
        low_speed_osc_stop <= 1'b1;
        step(3);
        `CHECK("low speed running", 1'b0, low_speed_running)
        snap;
        step(2 * LOW_SPEED_DIV);
        `CHECK("watchdog ticks", 0, n_wd - b_wd)
        low_speed_stoppable <= 1'b0;
        step(3);
        `CHECK("low speed running", 1'b1, low_speed_running)
        low_speed_stoppable <= 1'b1;
        step(3);
        low_speed_osc_stop <= 1'b0;
        step(3);
        `CHECK("low speed running", 1'b1, low_speed_running)
        snap;
        step(LOW_SPEED_DIV + 3);
        `CHECK("watchdog ticks", 1, n_wd - b_wd)
    endtask

    initial
    begin
        test_reset;
        test_sub_pins;
        test_cpu_sub;
        test_divider;
        test_highspeed;
        test_low_speed;
        test_done;
    end
endmodule // cpu_peripheral_clock_selector_tb
